// *** vfg_pkg.sv ***
// Purpose: Constants, types and register map of the voltage fuel gauge.
// Assumes: 10 MHz pclk, APB word registers at byte address 4 x index.
// Notes on behaviour
// [RL1] Battery voltage arrives as 12-bit converter codes; charge comes from a model.
// [RL2] Host programs ten voltage points and resistance points before use.
// [RL3] After reset the gauge is shut down: no sampling, no updates.
// [RL4] Once enabled, the host picks active or sleep mode; device follows.
// [RL5] Active mode samples every 0.125 s and updates charge every 1 s.
// [RL6] Sleep mode updates charge every 5 min and current every 37.5 s.
// [RL7] In sleep, current above 35 mA switches the gauge to active.
// [RL8] Host requests sleep only below 35 mA system current.
// [RL9] Discharge current is switch voltage difference over on-resistance.
// [RL10] Result registers hold sensed voltage plus resistance times current.
// [RL11] While charging, the current term is the charging current.
// [RL12] While discharging, the current term comes from the switch voltage.
// [RL13] Resistance at present temperature comes from programmed temperature points.
// [RL14] Internal temperature source gives only four resistance levels.
// [RL15] Host should write its battery temperature for better compensation.
// [RL16] Discharging below 20% charge scales resistance by the low-charge coefficient.
// [RL17] Charging scales resistance by the charging coefficient.
// [RL18] Enabling initialises charge straight from the compensated voltage.
// [RL19] Charge change per update is limited by the programmed step limit.
// [RL20] Bit 7 of register 0x25 reinitialises charge; use only at rest.
package vfg_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned SAMPLE_MS         = 125;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int unsigned ACTIVE_SOC_MS     = 1000;
  localparam int unsigned ACTIVE_SOC_TICKS  = ACTIVE_SOC_MS / SAMPLE_MS;
  localparam int unsigned SLEEP_CUR_MS      = 37_500;
  localparam int unsigned SLEEP_CUR_TICKS   = SLEEP_CUR_MS / SAMPLE_MS;
  localparam int unsigned SLEEP_SOC_MIN     = 5;
  localparam int unsigned SLEEP_SOC_SAMPLES = SLEEP_SOC_MIN * 60_000 / SLEEP_CUR_MS;
  localparam logic [11:0] WAKE_CURRENT_MA   = 12'h023;
  localparam logic [6:0]  LOW_SOC_PCT       = 7'h14;
  localparam logic [6:0]  SOC_PT_PCT        = 7'h0A;
  localparam int unsigned NUM_VPTS          = 10;
  localparam int unsigned NUM_RPTS          = 4;
  // Register indices
  localparam logic [7:0]  IDX_VPT0  = 8'h10;
  localparam logic [7:0]  IDX_RPT0  = 8'h1A;
  localparam logic [7:0]  IDX_HTEMP = 8'h1E;
  localparam logic [7:0]  IDX_KLOW  = 8'h1F;
  localparam logic [7:0]  IDX_KCHG  = 8'h20;
  localparam logic [7:0]  IDX_STEP  = 8'h21;
  localparam logic [7:0]  IDX_RDSON = 8'h22;
  localparam logic [7:0]  IDX_CTRL  = 8'h25;
  localparam logic [7:0]  IDX_VBATH = 8'h30;
  localparam logic [7:0]  IDX_VBATL = 8'h31;
  localparam logic [7:0]  IDX_SOC   = 8'h32;
  localparam logic [7:0]  IDX_ICUR  = 8'h33;
  localparam logic [7:0]  IDX_MODE  = 8'h34;
  // Control fields
  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned CTRL_SLP  = 1;
  localparam int unsigned CTRL_TSRC = 2;
  localparam int unsigned CTRL_INIT = 7;
  // Host temperature bands, code 0 is -2 C
  localparam logic [5:0]  TBAND1 = 6'h0C;
  localparam logic [5:0]  TBAND2 = 6'h1B;
  localparam logic [5:0]  TBAND3 = 6'h2F;
  localparam logic [7:0]  K_UNITY   = 8'h80;
  localparam logic [6:0]  STEP_RST  = 7'h01;
  localparam logic [7:0]  RDSON_RST = 8'h40;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b001,
    MODE_ACT = 3'b010,
    MODE_SLP = 3'b100
  } vfg_mode_e;

  typedef struct packed {
    logic                 enable;
    logic                 sleep_sel;
    logic                 tsrc_host;
    logic                 wake;
    logic                 init_pend;
    logic [9:0][11:0]     vpts;
    logic [3:0][7:0]      rpts;
    logic [5:0]           host_temp;
    logic [7:0]           klow;
    logic [7:0]           kchg;
    logic [6:0]           step;
    logic [7:0]           rdson;
    vfg_mode_e            mode;
    logic [20:0]          tick_cnt;
    logic [8:0]           sub_cnt;
    logic [2:0]           upd_cnt;
    logic                 start;
    logic                 calc;
    logic                 calc_soc;
    logic                 calc_init;
    logic [11:0]          smp_vbsns;
    logic [11:0]          smp_vsys;
    logic [11:0]          smp_vbat;
    logic [11:0]          smp_ichg;
    logic                 smp_chg;
    logic [1:0]           smp_lvl;
    logic [11:0]          vbat;
    logic [11:0]          icur;
    logic [6:0]           soc;
    logic [31:0]          prdata;
  } vfg_state_s;

  localparam vfg_state_s STATE_RST = '{mode: MODE_OFF, klow: K_UNITY, kchg: K_UNITY,
                                      step: STEP_RST, rdson: RDSON_RST, default: '0};
endpackage

// *** vfg_fuel_gauge.sv ***
// Purpose: Voltage fuel gauge core with APB register file.
// Assumes: converter codes valid while adc_start is high; same-clock inputs.
// Notes: soc_percent moves toward 10% model points, rate limited per update.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module vfg_fuel_gauge #(
  parameter int unsigned TICK_CYCLES = vfg_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Converter and charger side
  output logic             adc_start,
  input  wire logic [11:0] adc_vbsns,
  input  wire logic [11:0] adc_vsys,
  input  wire logic [11:0] adc_vbat,
  input  wire logic [11:0] adc_ichg,
  input  wire logic        charging,
  input  wire logic [1:0]  temp_level,
  // Result
  output logic [6:0]       soc_percent
);
  vfg_pkg::vfg_state_s s_r;
  vfg_pkg::vfg_state_s s_nxt;
  logic [7:0]  idx;
  logic        mapped;
  logic        wr;
  logic        wr_ctrl;
  logic [31:0] rd_val;
  logic [19:0] dis_q;
  logic [11:0] i_bat;
  logic [1:0]  lvl;
  logic [7:0]  k;
  logic [15:0] r_prod;
  logic [8:0]  r_eff;
  logic [20:0] drop_p;
  logic [13:0] vsum;
  logic [11:0] vcomp;
  logic [3:0]  n_below;
  logic [6:0]  target;
  logic [6:0]  diff;
  logic [6:0]  soc_step;
  logic [8:0]  sub_max;
  logic        tick;
  logic        go;

  assign idx         = paddr[9:2];
  assign pready      = psel & penable;
  assign pslverr     = psel & penable & ~mapped;
  assign wr          = psel & penable & pwrite & mapped;
  assign wr_ctrl     = wr && (idx == vfg_pkg::IDX_CTRL);
  assign prdata      = s_r.prdata;
  assign adc_start   = s_r.start;
  assign soc_percent = s_r.soc;

  // Compensation datapath, works on the last captured sample
  always_comb begin
    dis_q = 20'h00000;
    if (s_r.smp_vbat > s_r.smp_vsys && s_r.rdson != 8'h00) begin
      dis_q = {s_r.smp_vbat - s_r.smp_vsys, 8'h00} / {12'h000, s_r.rdson}; // RL9
    end
    if (s_r.smp_chg) begin
      i_bat = s_r.smp_ichg; // RL11
    end else begin
      i_bat = (dis_q[19:12] != 8'h00) ? 12'hFFF : dis_q[11:0]; // RL12
    end
    if (s_r.tsrc_host) begin
      if (s_r.host_temp < vfg_pkg::TBAND1) begin
        lvl = 2'h0;
      end else if (s_r.host_temp < vfg_pkg::TBAND2) begin
        lvl = 2'h1;
      end else if (s_r.host_temp < vfg_pkg::TBAND3) begin
        lvl = 2'h2;
      end else begin
        lvl = 2'h3;
      end
    end else begin
      lvl = s_r.smp_lvl; // RL14
    end
    if (s_r.smp_chg) begin
      k = s_r.kchg; // RL17
    end else if (s_r.soc < vfg_pkg::LOW_SOC_PCT) begin
      k = s_r.klow; // RL16
    end else begin
      k = vfg_pkg::K_UNITY;
    end
    r_prod = s_r.rpts[lvl] * k; // RL13
    r_eff  = r_prod[15:7];
    drop_p = r_eff * i_bat;
    vsum   = {2'h0, s_r.smp_vbsns} + {1'b0, drop_p[20:8]};
    vcomp  = (vsum[13:12] != 2'h0) ? 12'hFFF : vsum[11:0]; // RL10
    n_below = 4'h0;
    for (int j = 0; j < vfg_pkg::NUM_VPTS; j++) begin
      if (vcomp >= s_r.vpts[j]) begin
        n_below = n_below + 4'h1; // RL1
      end
    end
    target = 7'(n_below) * vfg_pkg::SOC_PT_PCT;
    if (target >= s_r.soc) begin
      diff     = target - s_r.soc;
      soc_step = (diff > s_r.step) ? s_r.soc + s_r.step : target; // RL19
    end else begin
      diff     = s_r.soc - target;
      soc_step = (diff > s_r.step) ? s_r.soc - s_r.step : target; // RL19
    end
  end

  // Register decode and read data
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    if (idx >= vfg_pkg::IDX_VPT0 && idx < vfg_pkg::IDX_RPT0) begin
      rd_val = {20'h00000, s_r.vpts[4'(idx - vfg_pkg::IDX_VPT0)]};
    end else if (idx >= vfg_pkg::IDX_RPT0 && idx < vfg_pkg::IDX_HTEMP) begin
      rd_val = {24'h000000, s_r.rpts[2'(idx - vfg_pkg::IDX_RPT0)]};
    end else begin
      case (idx)
        vfg_pkg::IDX_HTEMP: rd_val = {26'h0000000, s_r.host_temp};
        vfg_pkg::IDX_KLOW:  rd_val = {24'h000000, s_r.klow};
        vfg_pkg::IDX_KCHG:  rd_val = {24'h000000, s_r.kchg};
        vfg_pkg::IDX_STEP:  rd_val = {25'h0000000, s_r.step};
        vfg_pkg::IDX_RDSON: rd_val = {24'h000000, s_r.rdson};
        // Reinit bit is self clearing and reads zero
        vfg_pkg::IDX_CTRL:  rd_val = {29'h00000000, s_r.tsrc_host, s_r.sleep_sel, s_r.enable};
        vfg_pkg::IDX_VBATH: rd_val = {24'h000000, s_r.vbat[11:4]};
        vfg_pkg::IDX_VBATL: rd_val = {28'h0000000, s_r.vbat[3:0]};
        vfg_pkg::IDX_SOC:   rd_val = {25'h0000000, s_r.soc};
        vfg_pkg::IDX_ICUR:  rd_val = {20'h00000, s_r.icur};
        vfg_pkg::IDX_MODE:  rd_val = {28'h0000000, s_r.wake, s_r.mode};
        default:            mapped = 1'b0;
      endcase
    end
  end

  // Next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.start = 1'b0;
    s_nxt.calc  = 1'b0;
    tick        = 1'b0;
    sub_max     = 9'h000;
    if (psel && !penable && !pwrite) begin
      s_nxt.prdata = rd_val;
    end
    unique case (s_r.mode)
      vfg_pkg::MODE_OFF: sub_max = 9'h000;
      vfg_pkg::MODE_ACT: sub_max = 9'h000; // RL5
      vfg_pkg::MODE_SLP: sub_max = 9'(vfg_pkg::SLEEP_CUR_TICKS - 1); // RL6
      default:           sub_max = 9'h000;
    endcase
    if (s_r.mode != vfg_pkg::MODE_OFF) begin // RL3
      if (s_r.tick_cnt == 21'(TICK_CYCLES - 1)) begin
        s_nxt.tick_cnt = 21'h000000;
        tick           = 1'b1;
      end else begin
        s_nxt.tick_cnt = s_r.tick_cnt + 21'h000001;
      end
    end
    go = s_r.init_pend;
    if (tick) begin
      if (s_r.sub_cnt == sub_max) begin
        s_nxt.sub_cnt = 9'h000;
        go            = 1'b1;
      end else begin
        s_nxt.sub_cnt = s_r.sub_cnt + 9'h001;
      end
    end
    if (go && s_r.mode != vfg_pkg::MODE_OFF) begin
      s_nxt.start     = 1'b1;
      s_nxt.init_pend = 1'b0;
      s_nxt.calc_init = s_r.init_pend; // RL18
      // Three-bit counter wraps every eight samples in both modes
      s_nxt.calc_soc  = s_r.init_pend || (s_r.upd_cnt == 3'h7); // RL5 RL6
      s_nxt.upd_cnt   = s_r.upd_cnt + 3'h1;
    end
    if (wr) begin
      if (idx >= vfg_pkg::IDX_VPT0 && idx < vfg_pkg::IDX_RPT0) begin
        s_nxt.vpts[4'(idx - vfg_pkg::IDX_VPT0)] = pwdata[11:0];
      end else if (idx >= vfg_pkg::IDX_RPT0 && idx < vfg_pkg::IDX_HTEMP) begin
        s_nxt.rpts[2'(idx - vfg_pkg::IDX_RPT0)] = pwdata[7:0];
      end
      case (idx)
        vfg_pkg::IDX_HTEMP: s_nxt.host_temp = pwdata[5:0];
        vfg_pkg::IDX_KLOW:  s_nxt.klow = pwdata[7:0];
        vfg_pkg::IDX_KCHG:  s_nxt.kchg = pwdata[7:0];
        vfg_pkg::IDX_STEP:  s_nxt.step = pwdata[6:0];
        vfg_pkg::IDX_RDSON: s_nxt.rdson = pwdata[7:0];
        default:            s_nxt.rdson = s_nxt.rdson;
      endcase
    end
    if (wr_ctrl) begin
      s_nxt.enable    = pwdata[vfg_pkg::CTRL_EN];
      s_nxt.sleep_sel = pwdata[vfg_pkg::CTRL_SLP]; // RL4
      s_nxt.tsrc_host = pwdata[vfg_pkg::CTRL_TSRC];
      s_nxt.wake      = 1'b0;
      if ((pwdata[vfg_pkg::CTRL_EN] && !s_r.enable) || pwdata[vfg_pkg::CTRL_INIT]) begin
        s_nxt.init_pend = pwdata[vfg_pkg::CTRL_EN]; // RL18 RL20
      end
    end
    if (s_r.start) begin
      s_nxt.smp_vbsns = adc_vbsns;
      s_nxt.smp_vsys  = adc_vsys;
      s_nxt.smp_vbat  = adc_vbat;
      s_nxt.smp_ichg  = adc_ichg;
      s_nxt.smp_chg   = charging;
      s_nxt.smp_lvl   = temp_level;
      s_nxt.calc      = 1'b1;
    end
    if (s_r.calc) begin
      s_nxt.vbat = vcomp; // RL10
      s_nxt.icur = i_bat; // RL6
      if (s_r.calc_init) begin
        s_nxt.soc = target; // RL18
      end else if (s_r.calc_soc) begin
        s_nxt.soc = soc_step; // RL19
      end
      // Set wins over a same-cycle control write that keeps enable set
      if (s_r.mode == vfg_pkg::MODE_SLP && i_bat > vfg_pkg::WAKE_CURRENT_MA) begin
        s_nxt.wake = 1'b1; // RL7
      end
    end
    if (!s_nxt.enable) begin
      s_nxt.mode      = vfg_pkg::MODE_OFF; // RL3
      s_nxt.init_pend = 1'b0;
      s_nxt.wake      = 1'b0;
      s_nxt.start     = 1'b0;
      s_nxt.calc      = 1'b0;
    end else if (s_nxt.sleep_sel && !s_nxt.wake) begin
      s_nxt.mode = vfg_pkg::MODE_SLP; // RL4
    end else begin
      s_nxt.mode = vfg_pkg::MODE_ACT; // RL4 RL7
    end
    // Restart the timebase so each mode's first period is full length
    if (s_nxt.mode != s_r.mode) begin
      s_nxt.tick_cnt = 21'h000000;
      s_nxt.sub_cnt  = 9'h000;
      s_nxt.upd_cnt  = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= vfg_pkg::STATE_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge pclk iff ce); endclocking
  default disable iff (!presetn);

  property p_off_quiet;
    s_r.mode == vfg_pkg::MODE_OFF |-> !adc_start && !s_r.calc ##1 !adc_start;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("sampling while shut down"); // RL3

  property p_mode_follow;
    s_r.mode == (!s_r.enable ? vfg_pkg::MODE_OFF :
                 (s_r.sleep_sel && !s_r.wake) ? vfg_pkg::MODE_SLP : vfg_pkg::MODE_ACT);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode not as selected"); // RL4

  property p_sample_period;
    adc_start |-> $past(s_r.init_pend) || $past(s_r.tick_cnt) == 21'(TICK_CYCLES - 1);
  endproperty
  a_sample_period: assert property (p_sample_period) else $error("sample off the tick"); // RL5

  property p_soc_every_eighth;
    adc_start && !$past(s_r.init_pend) |-> s_r.calc_soc == ($past(s_r.upd_cnt) == 3'h7);
  endproperty
  a_soc_every_eighth: assert property (p_soc_every_eighth) else $error("bad update slot"); // RL5

  property p_cur_refresh;
    s_r.calc |=> s_r.icur == $past(i_bat);
  endproperty
  a_cur_refresh: assert property (p_cur_refresh) else $error("current not refreshed"); // RL6

  property p_wake;
    s_r.calc && s_r.mode == vfg_pkg::MODE_SLP && i_bat > vfg_pkg::WAKE_CURRENT_MA
      && s_nxt.enable |=> s_r.mode == vfg_pkg::MODE_ACT;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake above threshold"); // RL7

  property p_no_reverse;
    s_r.calc && !s_r.smp_chg && s_r.smp_vbat <= s_r.smp_vsys |=> s_r.icur == 12'h000;
  endproperty
  a_no_reverse: assert property (p_no_reverse) else $error("current without drop"); // RL9

  property p_vbat_result;
    s_r.calc |=> s_r.vbat == $past(vcomp) && s_r.vbat >= $past(s_r.smp_vbsns);
  endproperty
  a_vbat_result: assert property (p_vbat_result) else $error("result not compensated"); // RL10

  property p_chg_term;
    s_r.smp_chg |-> i_bat == s_r.smp_ichg && k == s_r.kchg;
  endproperty
  a_chg_term: assert property (p_chg_term) else $error("charge term wrong"); // RL11

  property p_low_coeff;
    !s_r.smp_chg && s_r.soc < vfg_pkg::LOW_SOC_PCT |-> k == s_r.klow;
  endproperty
  a_low_coeff: assert property (p_low_coeff) else $error("low charge coeff unused"); // RL16

  property p_init;
    s_r.calc && s_r.calc_init |=> s_r.soc == $past(target);
  endproperty
  a_init: assert property (p_init) else $error("init not direct"); // RL18

  property p_step;
    s_r.calc && s_r.calc_soc && !s_r.calc_init |=>
      {1'b0, s_r.soc} <= {1'b0, $past(s_r.soc)} + {1'b0, $past(s_r.step)} &&
      {1'b0, s_r.soc} + {1'b0, $past(s_r.step)} >= {1'b0, $past(s_r.soc)};
  endproperty
  a_step: assert property (p_step) else $error("step limit exceeded"); // RL19

  property p_reinit;
    wr_ctrl && pwdata[vfg_pkg::CTRL_INIT] && pwdata[vfg_pkg::CTRL_EN]
      |-> ##[1:4] (s_r.calc && s_r.calc_init);
  endproperty
  a_reinit: assert property (p_reinit) else $error("reinit not taken"); // RL20
endmodule

// *** vfg_conv_model.sv ***
// Purpose: Converter and charger side partner of the fuel gauge core.
// Assumes: codes are captured at the edge that ends each adc_start pulse.
// Notes: outside that cycle the lines show inverted codes, never stale ones.
`timescale 1ns/100ps
module vfg_conv_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Converter handshake
  input  wire logic        adc_start,
  output logic [11:0]      adc_vbsns,
  output logic [11:0]      adc_vsys,
  output logic [11:0]      adc_vbat,
  output logic [11:0]      adc_ichg,
  // Charger status
  output logic             charging,
  output logic [1:0]       temp_level
);
  logic [11:0] vbsns_v = 12'h500;
  logic [11:0] vsys_v  = 12'h100;
  logic [11:0] vbat_v  = 12'h100;
  logic [11:0] ichg_v  = 12'h000;
  logic        chg_v   = 1'b0;
  logic [1:0]  lvl_v   = 2'h0;
  int          n_smp   = 0;
  int          period  = 0;
  int          gap     = 0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_smp <= 0;
    end else begin
      gap  <= adc_start ? 0 : gap + 1;
      if (adc_start) begin
        n_smp  <= n_smp + 1;
        period <= gap + 1;
      end
    end
  end
  // Inverted codes off the capture cycle expose a late or early capture
  assign adc_vbsns  = adc_start ? vbsns_v : ~vbsns_v;
  assign adc_vsys   = adc_start ? vsys_v : ~vsys_v;
  assign adc_vbat   = adc_start ? vbat_v : ~vbat_v;
  assign adc_ichg   = adc_start ? ichg_v : ~ichg_v;
  assign charging   = chg_v;
  assign temp_level = lvl_v;
endmodule

// *** voltage_fuel_gauge_tb.sv ***
// Purpose: Self-checking bench of the fuel gauge core over APB.
// Assumes: short tick of 20 cycles; converter partner in vfg_conv_model.
// Notes: sleep waits are long, so the sleep scenario runs last.
`timescale 1ns/100ps
module voltage_fuel_gauge_tb;
  localparam int unsigned TICKS = 20;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        adc_start;
  logic [11:0] adc_vbsns;
  logic [11:0] adc_vsys;
  logic [11:0] adc_vbat;
  logic [11:0] adc_ichg;
  logic        charging;
  logic [1:0]  temp_level;
  logic [6:0]  soc_percent;
  int          miscompares = 0;
  int          compares    = 0;
  always #50 pclk = ~pclk;
  vfg_fuel_gauge #(.TICK_CYCLES(TICKS)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .adc_start(adc_start),
    .adc_vbsns(adc_vbsns), .adc_vsys(adc_vsys), .adc_vbat(adc_vbat), .adc_ichg(adc_ichg),
    .charging(charging), .temp_level(temp_level), .soc_percent(soc_percent));
  vfg_conv_model conv (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
    .adc_vbsns(adc_vbsns), .adc_vsys(adc_vsys), .adc_vbat(adc_vbat), .adc_ichg(adc_ichg),
    .charging(charging), .temp_level(temp_level));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Setup then access; held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) miscompares++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, v, d, e);
  endtask
  task rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    check(nm, d, exp);
  endtask
  task setc(input logic [11:0] bs, vs, vb, ic, input logic chg, input logic [1:0] lv);
    @(posedge pclk);
    conv.vbsns_v <= bs;
    conv.vsys_v  <= vs;
    conv.vbat_v  <= vb;
    conv.ichg_v  <= ic;
    conv.chg_v   <= chg;
    conv.lvl_v   <= lv;
  endtask
  // Waits for k further samples, then lets the results land
  task smp(input int k);
    int n0;
    int n;
    n0 = conv.n_smp;
    n = 0;
    while (conv.n_smp < n0 + k && n < k * (300 * TICKS + 50)) begin
      @(posedge pclk);
      n++;
    end
    if (n >= k * (300 * TICKS + 50)) miscompares++;
    repeat (3) @(posedge pclk);
  endtask
  task t_reset;
    logic [31:0] d;
    logic        e;
    rdchk("mode", vfg_pkg::IDX_MODE, 32'h1);
    rdchk("klow", vfg_pkg::IDX_KLOW, 32'h80);
    rdchk("kchg", vfg_pkg::IDX_KCHG, 32'h80);
    rdchk("step", vfg_pkg::IDX_STEP, 32'h1);
    rdchk("rdson", vfg_pkg::IDX_RDSON, 32'h40);
    wr(vfg_pkg::IDX_SOC, 32'h55);
    rdchk("soc ro", vfg_pkg::IDX_SOC, 32'h0);
    apb(1'b0, 8'h3F, 32'h0, d, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    repeat (100) @(posedge pclk);
    check("idle samples", 32'(conv.n_smp), 32'h0);
  endtask
  task t_init;
    for (int j = 0; j < 10; j++) wr(vfg_pkg::IDX_VPT0 + 8'(j), 32'(256 * (j + 1)));
    for (int l = 0; l < 4; l++) wr(vfg_pkg::IDX_RPT0 + 8'(l), 32'(32 * (l + 1)));
    wr(vfg_pkg::IDX_CTRL, 32'h1);
    smp(1);
    check("soc init", {25'h0, soc_percent}, 32'h32);
    rdchk("vbat hi", vfg_pkg::IDX_VBATH, 32'h50);
    rdchk("mode act", vfg_pkg::IDX_MODE, 32'h2);
  endtask
  task t_step;
    int n;
    setc(12'h900, 12'h100, 12'h100, 12'h000, 1'b0, 2'h0);
    n = 0;
    while (soc_percent === 7'h32 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("soc step", {25'h0, soc_percent}, 32'h33);
    n = 0;
    while (soc_percent === 7'h33 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("soc gap", 32'(n), 32'(8 * TICKS));
    check("soc step2", {25'h0, soc_percent}, 32'h34);
    check("act period", 32'(conv.period), 32'(TICKS));
  endtask
  task t_comp;
    setc(12'h500, 12'h100, 12'h110, 12'h000, 1'b0, 2'h0);
    wr(vfg_pkg::IDX_HTEMP, 32'h30);
    wr(vfg_pkg::IDX_CTRL, 32'h5);
    smp(2);
    rdchk("icur dis", vfg_pkg::IDX_ICUR, 32'h40);
    rdchk("vbat host", vfg_pkg::IDX_VBATH, 32'h52);
    wr(vfg_pkg::IDX_CTRL, 32'h1);
    setc(12'h500, 12'h100, 12'h110, 12'h000, 1'b0, 2'h1);
    smp(2);
    rdchk("vbat lvl1", vfg_pkg::IDX_VBATH, 32'h51);
    wr(vfg_pkg::IDX_KCHG, 32'h40);
    setc(12'h500, 12'h100, 12'h110, 12'h080, 1'b1, 2'h3);
    smp(2);
    rdchk("icur chg", vfg_pkg::IDX_ICUR, 32'h80);
    rdchk("vbat chg", vfg_pkg::IDX_VBATH, 32'h52);
  endtask
  task t_reinit;
    setc(12'h150, 12'h100, 12'h100, 12'h000, 1'b0, 2'h0);
    wr(vfg_pkg::IDX_KLOW, 32'h40);
    smp(1);
    wr(vfg_pkg::IDX_CTRL, 32'h81);
    smp(1);
    check("soc reinit", {25'h0, soc_percent}, 32'h0A);
    rdchk("ctrl b7", vfg_pkg::IDX_CTRL, 32'h1);
    setc(12'h150, 12'h100, 12'h110, 12'h000, 1'b0, 2'h0);
    smp(2);
    rdchk("vbat low", vfg_pkg::IDX_VBATL, 32'h4);
    rdchk("vbat lowh", vfg_pkg::IDX_VBATH, 32'h15);
  endtask
  task t_sleep;
    setc(12'h500, 12'h100, 12'h100, 12'h000, 1'b0, 2'h0);
    smp(1);
    wr(vfg_pkg::IDX_CTRL, 32'h3);
    rdchk("mode slp", vfg_pkg::IDX_MODE, 32'h4);
    setc(12'h500, 12'h100, 12'h100, 12'h023, 1'b1, 2'h0);
    smp(2);
    check("slp period", 32'(conv.period), 32'(300 * TICKS));
    rdchk("icur slp", vfg_pkg::IDX_ICUR, 32'h23);
    rdchk("no wake", vfg_pkg::IDX_MODE, 32'h4);
    setc(12'h500, 12'h100, 12'h100, 12'h024, 1'b1, 2'h0);
    smp(1);
    rdchk("wake", vfg_pkg::IDX_MODE, 32'hA);
  endtask
  initial begin
    #5_000_000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_init();
    t_step();
    t_comp();
    t_reinit();
    t_sleep();
    final_report();
  end
endmodule
